// ### core/dhf_core.sv
// Dual Hall loop fault supervisor with output encoding and AXI4-Lite registers
`timescale 1ns/100ps
module dhf_core
	import dhf_pkg::*;
#(
	parameter int BLANK_CYCLES = DHF_BLANK_CYC,
	parameter int SHDN_CYCLES = DHF_SHDN_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [DHF_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [DHF_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog front end comparators, supply window and loop current drives
	input wire dhf_cmp_t sensor_loop_a,
	input wire dhf_cmp_t sensor_loop_b,
	input wire logic supply_in_range,
	output dhf_drive_t drive_a,
	output dhf_drive_t drive_b,
	// Host control pins
	input wire logic mode_select,
	input wire logic output_enable,
	// Open-drain outputs: value is always low, enable low pulls the pin down
	output logic sensor_out_a,
	output logic sensor_out_a_oe_n,
	output logic sensor_out_b,
	output logic sensor_out_b_oe_n,
	output logic error_flag_n,
	output logic error_flag_n_oe_n
);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [DHF_SYNC_W-1:0] raw_in;
	logic [DHF_SYNC_W-1:0] s1_reg;
	logic [DHF_SYNC_W-1:0] s2_reg;
	logic [DHF_SYNC_W-1:0] s3_reg;
	logic [DHF_SYNC_W-1:0] filt_reg;
	dhf_cmp_t cmp_f [DHF_NCH];
	logic supply_f;
	logic mode_f;
	logic oe_f;
	logic mode_q_reg;
	logic oe_q_reg;
	logic mode_fall;
	logic mode_rise;
	logic oe_rise;

	assign raw_in = {sensor_loop_b, sensor_loop_a, supply_in_range, mode_select, output_enable};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			filt_reg <= '0;
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// A rise counts only once stages two and three agree; a fall counts as soon as they differ
			filt_reg <= (s2_reg & s3_reg) | (filt_reg & ~(s2_reg ^ s3_reg));
		end
	end

	assign oe_f = filt_reg[0];
	assign mode_f = filt_reg[1];
	assign supply_f = filt_reg[2];
	assign cmp_f[0] = filt_reg[7:3];
	assign cmp_f[1] = filt_reg[12:8];

	// edges taken from the filtered value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q_reg <= 1'b0;
			oe_q_reg <= 1'b0;
		end else begin
			mode_q_reg <= mode_f;
			oe_q_reg <= oe_f;
		end
	end

	assign mode_fall = mode_q_reg & ~mode_f;
	assign mode_rise = ~mode_q_reg & mode_f;
	assign oe_rise = ~oe_q_reg & oe_f;

	////////////////////////////////////////////////////////////////////////////
	// Shutdown control

	logic shdn_reg;
	logic [DHF_SHDN_W-1:0] shdn_cnt_reg;
	logic shdn_arm;
	logic restart_reg;
	logic off_cond;

	assign shdn_arm = ~oe_f & ~mode_f & ~shdn_reg;
	// Channels are unpowered while the supply is bad or the part sleeps
	assign off_cond = ~supply_f | shdn_reg;

	// qualify both pins low for the delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shdn_cnt_reg <= '0;
		end else if (shdn_arm) begin
			shdn_cnt_reg <= shdn_cnt_reg + 1'b1;
		end else begin
			shdn_cnt_reg <= '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shdn_reg <= 1'b0;
		end else if (shdn_arm && shdn_cnt_reg == DHF_SHDN_W'(SHDN_CYCLES - 1)) begin
			shdn_reg <= 1'b1;
		end else if (shdn_reg && (oe_rise || mode_rise)) begin
			shdn_reg <= 1'b0;
		end
	end

	a_shdn_enter: assert property ($rose(shdn_reg) |->
		$past(shdn_cnt_reg) == DHF_SHDN_W'(SHDN_CYCLES - 1) && $past(!oe_f && !mode_f))
		else $error("shutdown entered without full qualification");
	a_shdn_exit: assert property (shdn_reg && (oe_rise || mode_rise) |=> !shdn_reg)
		else $error("shutdown not left on rising pin");

	////////////////////////////////////////////////////////////////////////////
	// Per-channel supervision

	dhf_ch_state_t st_reg [DHF_NCH];
	logic [1:0] code [DHF_NCH];
	logic [DHF_NCH-1:0] blank;
	logic [DHF_NCH-1:0] run;
	logic [DHF_NCH-1:0] level;
	logic [DHF_NCH-1:0] gnd_evt;
	dhf_drive_t drive_reg [DHF_NCH];

	for (genvar i = 0; i < DHF_NCH; i++) begin : g_ch
		dhf_ch_state_t st_next;
		logic [DHF_BLANK_W-1:0] blank_cnt_reg;
		logic level_reg;
		logic blank_done;

		assign blank_done = blank_cnt_reg == DHF_BLANK_W'(BLANK_CYCLES - 1);

		always_comb begin
			st_next = st_reg[i];
			// supply loss forces the channel off
			if (off_cond) begin
				st_next = DHF_CH_OFF;
			end else begin
				unique case (st_reg[i])
					DHF_CH_OFF: st_next = DHF_CH_BLANK;
					// ground short ignored while the load charges
					DHF_CH_BLANK: if (blank_done) st_next = DHF_CH_RUN;
					DHF_CH_RUN: begin
						if (cmp_f[i].short_gnd) begin
							st_next = DHF_CH_SHGND;
						end else if (cmp_f[i].open) begin
							st_next = DHF_CH_OPEN;
						// short to battery shuts the source
						end else if (cmp_f[i].short_bat) begin
							st_next = DHF_CH_SHBAT;
						end
					end
					DHF_CH_OPEN: if (!cmp_f[i].open) st_next = DHF_CH_BLANK;
					DHF_CH_SHBAT: if (!cmp_f[i].short_bat) st_next = DHF_CH_RUN;
					DHF_CH_SHGND: begin
						if (cmp_f[i].open) begin
							st_next = DHF_CH_OPEN;
						// restart on mode fall or software
						end else if (mode_fall || restart_reg) begin
							st_next = DHF_CH_BLANK;
						end
					end
					default: st_next = DHF_CH_OFF;
				endcase
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				st_reg[i] <= DHF_CH_OFF;
			end else begin
				st_reg[i] <= st_next;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn || st_reg[i] != DHF_CH_BLANK) begin
				blank_cnt_reg <= '0;
			end else begin
				blank_cnt_reg <= blank_cnt_reg + 1'b1;
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				level_reg <= 1'b0;
			end else if (cmp_f[i].cur_hi) begin
				level_reg <= 1'b1;
			end else if (cmp_f[i].cur_lo) begin
				level_reg <= 1'b0;
			end
		end

		// latched ground short keeps only the pullup
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				drive_reg[i] <= '0;
			end else begin
				drive_reg[i].supply_en <= st_next == DHF_CH_BLANK || st_next == DHF_CH_RUN;
				drive_reg[i].pullup_en <= st_next == DHF_CH_SHGND;
			end
		end

		assign blank[i] = st_reg[i] == DHF_CH_BLANK;
		assign run[i] = st_reg[i] == DHF_CH_RUN;
		assign level[i] = level_reg;
		assign gnd_evt[i] = st_next == DHF_CH_SHGND && st_reg[i] != DHF_CH_SHGND;
		assign code[i] = st_reg[i] == DHF_CH_OPEN ? DHF_CODE_OPEN :
			st_reg[i] == DHF_CH_SHBAT ? DHF_CODE_SHBAT :
			st_reg[i] == DHF_CH_SHGND ? DHF_CODE_SHGND : DHF_CODE_NONE;

		sequence s_latched_unload;
			st_reg[i] == DHF_CH_SHGND && cmp_f[i].open && !off_cond;
		endsequence
		sequence s_reload;
			st_reg[i] == DHF_CH_OPEN && !cmp_f[i].open && !off_cond;
		endsequence

		a_blank_length: assert property (blank[i] && !off_cond && !blank_done |=> blank[i])
			else $error("blanking ended early");
		a_shgnd_latch: assert property (st_reg[i] == DHF_CH_SHGND && !cmp_f[i].open &&
			!mode_fall && !restart_reg && !off_cond |=> st_reg[i] == DHF_CH_SHGND ##0
			drive_reg[i].pullup_en && !drive_reg[i].supply_en)
			else $error("ground short latch lost");
		a_unload_reload: assert property (s_latched_unload |=> st_reg[i] == DHF_CH_OPEN)
			else $error("unloaded ground latch did not report open");
		a_reload_blank: assert property (s_reload |=> blank[i])
			else $error("reloaded open channel did not restart blanking");
		a_mode_restart: assert property (st_reg[i] == DHF_CH_SHGND && mode_fall &&
			!cmp_f[i].open && !off_cond |=> blank[i] ##1 drive_reg[i].supply_en)
			else $error("mode fall did not restart channel");
		a_shbat_resume: assert property (st_reg[i] == DHF_CH_SHBAT &&
			!cmp_f[i].short_bat && !off_cond |=> run[i])
			else $error("short to battery did not clear");
		a_supply_off: assert property (!supply_f |=> st_reg[i] == DHF_CH_OFF ##1
			!drive_reg[i].supply_en || supply_f)
			else $error("channel still powered with bad supply");
	end

	assign drive_a = drive_reg[0];
	assign drive_b = drive_reg[1];

	////////////////////////////////////////////////////////////////////////////
	// Output encoding

	logic err_v;
	logic [1:0] pair_v;
	logic hiz;
	logic pin_low_reg;
	logic out_a_oe_n_reg;
	logic out_b_oe_n_reg;
	logic err_oe_n_reg;
	logic [2:0] lvl_reg;

	// codes formed from present state only
	always_comb begin
		err_v = 1'b1;
		pair_v = 2'b00;
		if (!mode_f) begin
			err_v = ~(~supply_f | (|blank) | (code[0] != DHF_CODE_NONE) |
				(code[1] != DHF_CODE_NONE) | (st_reg[0] == DHF_CH_OFF) |
				(st_reg[1] == DHF_CH_OFF));
			pair_v = {run[0] & level[0], run[1] & level[1]};
		end else if (!supply_f || (|blank) || st_reg[0] == DHF_CH_OFF ||
			st_reg[1] == DHF_CH_OFF) begin
			err_v = 1'b1;
			pair_v = 2'b00;
		end else if (code[0] != DHF_CODE_NONE || code[1] == DHF_CODE_NONE) begin
			err_v = 1'b0;
			pair_v = code[0];
		end else begin
			err_v = 1'b1;
			pair_v = code[1];
		end
	end

	assign hiz = ~oe_f | shdn_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_low_reg <= 1'b0;
			out_a_oe_n_reg <= 1'b1;
			out_b_oe_n_reg <= 1'b1;
			err_oe_n_reg <= 1'b1;
			lvl_reg <= 3'h0;
		end else begin
			pin_low_reg <= 1'b0;
			out_a_oe_n_reg <= hiz | pair_v[1];
			out_b_oe_n_reg <= hiz | pair_v[0];
			err_oe_n_reg <= hiz | err_v;
			lvl_reg <= {err_v, pair_v};
		end
	end

	assign sensor_out_a = pin_low_reg;
	assign sensor_out_b = pin_low_reg;
	assign error_flag_n = pin_low_reg;
	assign sensor_out_a_oe_n = out_a_oe_n_reg;
	assign sensor_out_b_oe_n = out_b_oe_n_reg;
	assign error_flag_n_oe_n = err_oe_n_reg;

	a_hiz_disable: assert property (!oe_f || shdn_reg |=> sensor_out_a_oe_n &&
		sensor_out_b_oe_n && error_flag_n_oe_n)
		else $error("output driven while disabled");
	a_normal_live: assert property (!mode_f && oe_f && !shdn_reg && run == 2'b11 &&
		supply_f |=> error_flag_n_oe_n && sensor_out_a_oe_n == $past(level[0]) &&
		sensor_out_b_oe_n == $past(level[1]))
		else $error("normal outputs do not follow sensors");
	a_fault_low: assert property (!mode_f && oe_f && !shdn_reg && !run[0] |=>
		!error_flag_n_oe_n && !sensor_out_a_oe_n)
		else $error("faulty channel output not forced low");
	a_supply_all: assert property (!supply_f && !mode_f && oe_f && !shdn_reg |=>
		!error_flag_n_oe_n && !sensor_out_a_oe_n && !sensor_out_b_oe_n)
		else $error("bad supply did not force outputs low");
	a_mode_select_prio: assert property (mode_f && oe_f && !shdn_reg && supply_f && run[1] &&
		code[0] != DHF_CODE_NONE && blank == 2'b00 |=> !error_flag_n_oe_n &&
		{sensor_out_a_oe_n, sensor_out_b_oe_n} == $past(code[0]))
		else $error("channel A code not shown first");
	a_mode_select_b_code: assert property (mode_f && oe_f && !shdn_reg && run[0] &&
		code[1] != DHF_CODE_NONE && supply_f |=> error_flag_n_oe_n &&
		{sensor_out_a_oe_n, sensor_out_b_oe_n} == $past(code[1]))
		else $error("channel B code wrong");

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite register slave

	logic aw_hold_reg;
	logic w_hold_reg;
	logic [DHF_ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic do_write;
	logic [1:0] evt_reg;
	logic [31:0] stat_word;

	assign do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= DHF_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg[3:2] == DHF_STAT_OFS[3:2] ||
					awaddr_reg[3:2] == DHF_CTRL_OFS[3:2] ||
					awaddr_reg[3:2] == DHF_EVT_OFS[3:2]) ? DHF_RESP_OKAY : DHF_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// software restart pulse for latched channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= do_write && awaddr_reg[3:2] == DHF_CTRL_OFS[3:2] && wstrb_reg[0] &&
				wdata_reg[DHF_CTRL_RESTART_BIT];
		end
	end

	// Sticky ground-short events; a new event beats a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_reg <= DHF_EVT_RST;
		end else if (do_write && awaddr_reg[3:2] == DHF_EVT_OFS[3:2] && wstrb_reg[0]) begin
			evt_reg <= (evt_reg & ~wdata_reg[1:0]) | gnd_evt;
		end else begin
			evt_reg <= evt_reg | gnd_evt;
		end
	end

	always_comb begin
		stat_word = 32'h0;
		stat_word[DHF_ST_A_LSB +: 3] = st_reg[0];
		stat_word[DHF_ST_B_LSB +: 3] = st_reg[1];
		stat_word[DHF_LVL_LSB +: 2] = level;
		stat_word[DHF_SUPPLY_BIT] = supply_f;
		stat_word[DHF_SHDN_BIT] = shdn_reg;
		stat_word[DHF_MODE_BIT] = mode_f;
		stat_word[DHF_ERR_BIT] = lvl_reg[2];
		stat_word[DHF_OUT_LSB +: 2] = lvl_reg[1:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= DHF_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= DHF_RESP_OKAY;
			unique case (s_axi_araddr[3:2])
				DHF_CTRL_OFS[3:2]: s_axi_rdata <= 32'h0;
				DHF_STAT_OFS[3:2]: s_axi_rdata <= stat_word;
				DHF_EVT_OFS[3:2]: s_axi_rdata <= {30'h0, evt_reg};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= DHF_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : dhf_core

// ### pkg/dhf_pkg.sv
// Shared constants and types for the dual Hall fault supervisor
package dhf_pkg;
	localparam int DHF_NCH = 2;
	localparam int DHF_CLK_HZ = 40_000_000;
	// Shutdown qualification delay in microseconds, and its cycle count rounded up
	localparam int DHF_SHDN_US = 40;
	localparam int DHF_SHDN_CYC = (DHF_SHDN_US * DHF_CLK_HZ + 999_999) / 1_000_000;
	localparam int DHF_BLANK_CYC = 64;
	localparam int DHF_BLANK_W = 16;
	localparam int DHF_SHDN_W = 12;
	localparam int DHF_SYNC_W = 13;
	localparam int DHF_ADDR_W = 4;

	// Register byte offsets
	localparam logic [3:0] DHF_CTRL_OFS = 4'h0;
	localparam logic [3:0] DHF_STAT_OFS = 4'h4;
	localparam logic [3:0] DHF_EVT_OFS = 4'h8;
	// Control bit: one-shot restart of latched short-to-ground channels
	localparam int DHF_CTRL_RESTART_BIT = 0;
	localparam logic [1:0] DHF_EVT_RST = 2'h0;

	// Status field positions
	localparam int DHF_ST_A_LSB = 0;
	localparam int DHF_ST_B_LSB = 3;
	localparam int DHF_LVL_LSB = 6;
	localparam int DHF_SUPPLY_BIT = 8;
	localparam int DHF_SHDN_BIT = 9;
	localparam int DHF_MODE_BIT = 10;
	localparam int DHF_ERR_BIT = 11;
	localparam int DHF_OUT_LSB = 12;

	localparam logic [1:0] DHF_RESP_OKAY = 2'h0;
	localparam logic [1:0] DHF_RESP_SLVERR = 2'h2;

	// Diagnostic fault codes on the output pair
	localparam logic [1:0] DHF_CODE_NONE = 2'h0;
	localparam logic [1:0] DHF_CODE_OPEN = 2'h1;
	localparam logic [1:0] DHF_CODE_SHBAT = 2'h2;
	localparam logic [1:0] DHF_CODE_SHGND = 2'h3;

	typedef enum logic [2:0] {
		DHF_CH_OFF,
		DHF_CH_BLANK,
		DHF_CH_RUN,
		DHF_CH_OPEN,
		DHF_CH_SHBAT,
		DHF_CH_SHGND
	} dhf_ch_state_t;

	// Comparator results of one loop input
	typedef struct packed {
		logic cur_hi;
		logic cur_lo;
		logic open;
		logic short_bat;
		logic short_gnd;
	} dhf_cmp_t;

	// Current source controls of one loop input
	typedef struct packed {
		logic supply_en;
		logic pullup_en;
	} dhf_drive_t;
endpackage : dhf_pkg

// ### test/dhf_host_model.sv
// Host model: drives the mode and enable pins, reads the open-drain outputs
`timescale 1ns/100ps
module dhf_host_model (
	// Clock
	input wire logic aclk,
	// Requests from the bench
	input wire logic req_mode,
	input wire logic req_oe,
	// Control pins towards the device
	output logic mode_select,
	output logic output_enable,
	// Open-drain enables from the device
	input wire logic out_a_oe_n,
	input wire logic out_b_oe_n,
	input wire logic err_oe_n,
	// Line levels as the host reads them
	output logic pin_a,
	output logic pin_b,
	output logic pin_err
);
	////////////////////////////////////////////////////////////
	// mode pin
	// enable pin
	// Pins move only just after an edge, like a clocked port
	always @(posedge aclk) begin
		mode_select <= req_mode;
		output_enable <= req_oe;
	end
	////////////////////////////////////////////////////////////
	// Pullups: a released line reads high, a pulled line low
	assign pin_a = out_a_oe_n ? 1'b1 : 1'b0;
	assign pin_b = out_b_oe_n ? 1'b1 : 1'b0;
	assign pin_err = err_oe_n ? 1'b1 : 1'b0;
endmodule : dhf_host_model

// ### test/testbench.sv
// Self-checking bench for the dual Hall fault supervisor
`timescale 1ns/100ps
module testbench;
	import dhf_pkg::*;
	// Short counts keep the run brief
	localparam int BLANK = 16;
	localparam int SHDN = 8;
	localparam dhf_cmp_t C_HI = 5'h10;
	localparam dhf_cmp_t C_LO = 5'h08;
	localparam dhf_cmp_t C_OPEN = 5'h04;
	localparam dhf_cmp_t C_SB = 5'h02;
	localparam dhf_cmp_t C_SG = 5'h01;
	logic aclk, aresetn;
	logic [DHF_ADDR_W-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	dhf_cmp_t loop_a, loop_b;
	dhf_drive_t drive_a, drive_b;
	logic supply_ok, req_mode, req_oe, mode_select, output_enable;
	logic out_a, out_a_oe_n, out_b, out_b_oe_n, err, err_oe_n, pin_a, pin_b, pin_err;
	int error_cnt, checked;
	dhf_cmp_t bfault [3] = '{C_OPEN, C_SB, C_SG};
	logic [1:0] bcode [3] = '{DHF_CODE_OPEN, DHF_CODE_SHBAT, DHF_CODE_SHGND};

	dhf_core #(.BLANK_CYCLES(BLANK), .SHDN_CYCLES(SHDN)) i_dhf_core (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sensor_loop_a(loop_a), .sensor_loop_b(loop_b), .supply_in_range(supply_ok),
		.drive_a(drive_a), .drive_b(drive_b),
		.mode_select(mode_select), .output_enable(output_enable),
		.sensor_out_a(out_a), .sensor_out_a_oe_n(out_a_oe_n),
		.sensor_out_b(out_b), .sensor_out_b_oe_n(out_b_oe_n),
		.error_flag_n(err), .error_flag_n_oe_n(err_oe_n));

	dhf_host_model i_dhf_host_model (
		.aclk(aclk), .req_mode(req_mode), .req_oe(req_oe),
		.mode_select(mode_select), .output_enable(output_enable),
		.out_a_oe_n(out_a_oe_n), .out_b_oe_n(out_b_oe_n), .err_oe_n(err_oe_n),
		.pin_a(pin_a), .pin_b(pin_b), .pin_err(pin_err));

	////////////////////////////////////////////////////////////
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check_word

	// Pin triple is {error flag, output a, output b} as line levels
	task automatic check_pins(input string what, input logic [2:0] exp);
		check_word(what, {29'h0, exp}, {29'h0, pin_err, pin_a, pin_b});
	endtask : check_pins

	// Sample a step after the edge so that its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : cyc

	task automatic drive(input dhf_cmp_t a, input dhf_cmp_t b, input logic sup,
		input logic m, input logic oe);
		@(posedge aclk);
		loop_a <= a;
		loop_b <= b;
		supply_ok <= sup;
		req_mode <= m;
		req_oe <= oe;
	endtask : drive

	////////////////////////////////////////////////////////////
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (!w_done && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		#1;
	endtask : axi_write

	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		#1;
	endtask : axi_read

	////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Whole sequence takes about 700 cycles
	initial begin
		repeat (6000) @(posedge aclk);
		error_cnt++;
		results();
	end

	initial begin
		aresetn = 1'b0;
		awaddr = 4'h0;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 4'h0;
		arvalid = 1'b0;
		rready = 1'b0;
		loop_a = C_HI;
		loop_b = C_LO;
		supply_ok = 1'b1;
		req_mode = 1'b0;
		req_oe = 1'b1;
		error_cnt = 0;
		checked = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(10);
		check_pins("power-up pins", 3'b000); // blanking low
		cyc(40);
		check_pins("run pins", 3'b110); // live levels
		drive(C_LO, C_HI, 1'b1, 1'b0, 1'b1);
		cyc(10);
		check_pins("swapped pins", 3'b101); // levels follow
		drive(C_OPEN, C_HI, 1'b1, 1'b0, 1'b1);
		cyc(10);
		check_pins("open a normal", 3'b001); // one channel low
		check_word("pin values", 32'h0, {29'h0, err, out_a, out_b}); // drains pull low
		check_word("supply a", 32'h0, {31'h0, drive_a.supply_en}); // current off
		$display("Test normal mode done");
		drive(C_OPEN, C_HI, 1'b1, 1'b1, 1'b1);
		cyc(10);
		check_pins("open a mode_select", 3'b001); // channel a code
		drive(C_OPEN, C_SB, 1'b1, 1'b1, 1'b1);
		cyc(10);
		check_pins("a hides b", 3'b001); // channel a first
		drive(C_HI, C_SB, 1'b1, 1'b1, 1'b1);
		cyc(10);
		check_pins("restart blank", 3'b100); // blanking masks
		cyc(40);
		check_pins("b short bat", 3'b110); // channel b code
		drive(C_HI, C_LO, 1'b1, 1'b1, 1'b1);
		cyc(10);
		check_pins("no fault", 3'b000); // live code
		for (int i = 0; i < 3; i++) begin
			drive(C_HI, bfault[i], 1'b1, 1'b1, 1'b1);
			cyc(10);
			check_pins("b code", {1'b1, bcode[i]}); // channel b codes
			drive(C_HI, C_LO, 1'b1, 1'b1, 1'b1);
			cyc(40);
		end
		check_pins("b latched", 3'b111); // ground short holds
		check_word("drive b", 32'h1, {30'h0, drive_b}); // pullup only
		axi_read(DHF_STAT_OFS, rd, resp);
		check_word("state b", 32'h5, {29'h0, rd[DHF_ST_B_LSB+:3]}); // latched state
		axi_read(DHF_EVT_OFS, rd, resp);
		check_word("event", 32'h2, rd & 32'h3); // entry recorded
		axi_write(DHF_EVT_OFS, 32'h2, resp);
		axi_read(DHF_EVT_OFS, rd, resp);
		check_word("event cleared", 32'h0, rd & 32'h3); // cleared by write
		drive(C_HI, C_LO, 1'b1, 1'b0, 1'b1);
		cyc(10);
		check_pins("b restart", 3'b010); // falling edge restart
		cyc(40);
		check_pins("b running", 3'b110); // back to levels
		$display("Test diagnostic codes done");
		drive(C_SG, C_LO, 1'b1, 1'b1, 1'b1);
		cyc(10);
		check_pins("a ground", 3'b011); // ground code
		drive(C_OPEN, C_LO, 1'b1, 1'b1, 1'b1);
		cyc(10);
		check_pins("a unloaded", 3'b001); // open after latch
		drive(C_HI, C_LO, 1'b1, 1'b1, 1'b1);
		cyc(10);
		check_pins("a reloaded", 3'b100); // blanking step
		cyc(40);
		check_pins("a recovered", 3'b000); // no fault step
		// The short must outlast the input filter, a single cycle is rejected
		drive(C_SG, C_LO, 1'b1, 1'b1, 1'b1);
		cyc(10);
		check_pins("a latched", 3'b011); // ground code again
		drive(C_HI, C_LO, 1'b1, 1'b1, 1'b1);
		cyc(10);
		check_pins("a held", 3'b011); // stays latched
		axi_write(DHF_CTRL_OFS, 32'h1, resp);
		check_word("ctrl resp", {30'h0, DHF_RESP_OKAY}, {30'h0, resp}); // restart write
		cyc(4);
		check_pins("soft restart", 3'b100); // restart blanking
		$display("Test ground latch done");
		drive(C_HI, C_LO, 1'b0, 1'b0, 1'b1);
		cyc(10);
		check_pins("supply bad", 3'b000); // all low
		check_word("drives off", 32'h0, {28'h0, drive_a, drive_b}); // both shut off
		drive(C_HI, C_LO, 1'b1, 1'b0, 1'b1);
		cyc(10);
		check_pins("supply back", 3'b000); // blanking restart
		cyc(40);
		check_pins("supply run", 3'b110); // levels again
		$display("Test supply done");
		drive(C_HI, C_LO, 1'b1, 1'b1, 1'b0);
		cyc(30);
		check_pins("disabled", 3'b111); // lines released
		axi_read(DHF_STAT_OFS, rd, resp);
		check_word("no shutdown", 32'h0, {31'h0, rd[DHF_SHDN_BIT]}); // mode high blocks
		drive(C_HI, C_LO, 1'b1, 1'b0, 1'b0);
		cyc(30);
		axi_read(DHF_STAT_OFS, rd, resp);
		check_word("shutdown", 32'h1, {31'h0, rd[DHF_SHDN_BIT]}); // both low
		check_pins("shutdown pins", 3'b111); // lines released
		drive(C_HI, C_LO, 1'b1, 1'b0, 1'b1);
		cyc(10);
		axi_read(DHF_STAT_OFS, rd, resp);
		check_word("wake", 32'h0, {31'h0, rd[DHF_SHDN_BIT]}); // enable rise wakes
		check_pins("wake pins", 3'b000); // restart blanking
		cyc(40);
		check_pins("wake run", 3'b110); // levels again
		$display("Test enable and shutdown done");
		axi_write(4'hc, 32'h1, resp);
		check_word("unmapped write", {30'h0, DHF_RESP_SLVERR}, {30'h0, resp}); // bus error
		axi_read(4'hc, rd, resp);
		check_word("unmapped resp", {30'h0, DHF_RESP_SLVERR}, {30'h0, resp}); // bus error
		check_word("unmapped data", 32'h0, rd); // reads zero
		axi_write(DHF_STAT_OFS, 32'hffff_ffff, resp);
		check_word("status write", {30'h0, DHF_RESP_OKAY}, {30'h0, resp}); // ignored
		$display("Test register bus done");
		results();
	end
endmodule : testbench
